/* verilog/pssso_params.svh */
// Purpose: shared constants of the pipelined sram select/output block
// Assumes: included by bare name from the design modules
// Notes: offsets are byte addresses on the axi4-lite register port
`ifndef PSSSO_PARAMS_SVH
`define PSSSO_PARAMS_SVH

// width of one byte lane on the data pins (8 data bits plus parity)
`define PSSSO_LANE_W 9
// cycles from a load or deselect edge to the data-pin effect
`define PSSSO_DATA_LAT 2
// bits of the burst counter (four-word bursts)
`define PSSSO_BURST_W 2

`define PSSSO_CTRL_OFS 4'h0
`define PSSSO_STAT_OFS 4'h4
`define PSSSO_CTRL_RST 32'h0000_0000
`define PSSSO_CTRL_HIZ_BIT 0

`define PSSSO_STAT_S1_BIT 0
`define PSSSO_STAT_S2_BIT 1
`define PSSSO_STAT_DRV_BIT 2
`define PSSSO_STAT_ST_LSB 3
`define PSSSO_STAT_CNT_LSB 6

`define PSSSO_RESP_OKAY 2'h0
`define PSSSO_RESP_DECERR 2'h3

`endif

/* verilog/pssso_pkg.sv */
// Purpose: types of the pipelined sram select/output block
// Assumes: nothing
// Notes: burst state is one-hot
package pssso_pkg;

  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_rd = 3'h2,
    st_wr = 3'h4
  } pssso_burst_t;

endpackage : pssso_pkg

/* verilog/pssso_burst.sv */
// Purpose: low address bits of a burst beat, linear or interleaved
// Assumes: count wraps at the burst length
// Notes: purely combinational
`timescale 1ns/10ps
`include "pssso_params.svh"

module pssso_burst #(
  parameter int CNT_W = `PSSSO_BURST_W
) (
  input wire logic [CNT_W-1:0] base_low, // low bits of the loaded address
  input wire logic [CNT_W-1:0] count, // beat number within the burst
  input wire logic interleave, // high selects interleaved order
  output logic [CNT_W-1:0] addr_low // low bits used for this beat
);

  wire [CNT_W-1:0] lin_low = CNT_W'(base_low + count);
  wire [CNT_W-1:0] ilv_low = base_low ^ count;

  assign addr_low = interleave ? ilv_low : lin_low;

endmodule : pssso_burst

/* verilog/pssso_axil.sv */
// Purpose: axi4-lite slave with a control and a status register
// Assumes: one write and one read outstanding at most
// Notes: unmapped offsets answer decerr, reads of them give zero
`timescale 1ns/10ps
`include "pssso_params.svh"

module pssso_axil (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [3:0] s_axil_awaddr, // write address
  input wire logic s_axil_awvalid, // write address valid
  output logic s_axil_awready, // write address ready
  input wire logic [31:0] s_axil_wdata, // write data
  input wire logic [3:0] s_axil_wstrb, // write byte strobes
  input wire logic s_axil_wvalid, // write data valid
  output logic s_axil_wready, // write data ready
  output logic [1:0] s_axil_bresp, // write response
  output logic s_axil_bvalid, // write response valid
  input wire logic s_axil_bready, // write response ready
  input wire logic [3:0] s_axil_araddr, // read address
  input wire logic s_axil_arvalid, // read address valid
  output logic s_axil_arready, // read address ready
  output logic [31:0] s_axil_rdata, // read data
  output logic [1:0] s_axil_rresp, // read response
  output logic s_axil_rvalid, // read data valid
  input wire logic s_axil_rready, // read data ready
  input wire logic [31:0] status, // live block state
  output logic force_hiz // control bit: keep data pins released
);

  logic [3:0] awaddr_ff;
  logic [31:0] ctrl_ff;
  logic [7:0] wbyte_ff;

  wire aw_hs = s_axil_awvalid & s_axil_awready;
  wire w_hs = s_axil_wvalid & s_axil_wready;
  wire do_wr = ~s_axil_awready & ~s_axil_wready & ~s_axil_bvalid;
  wire b_hs = s_axil_bvalid & s_axil_bready;
  wire ar_hs = s_axil_arvalid & s_axil_arready;
  wire r_hs = s_axil_rvalid & s_axil_rready;
  wire wr_ctrl = do_wr & (awaddr_ff == `PSSSO_CTRL_OFS);
  wire wr_map = wr_ctrl | (awaddr_ff == `PSSSO_STAT_OFS);
  wire rd_ctrl = s_axil_araddr == `PSSSO_CTRL_OFS;
  wire rd_stat = s_axil_araddr == `PSSSO_STAT_OFS;
  wire [31:0] rd_word = rd_ctrl ? ctrl_ff : (rd_stat ? status : 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_awready <= 1'b1;
      s_axil_wready <= 1'b1;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp <= `PSSSO_RESP_OKAY;
      awaddr_ff <= 4'h0;
      ctrl_ff <= `PSSSO_CTRL_RST;
    end else begin
      if (aw_hs) begin
        s_axil_awready <= 1'b0;
        awaddr_ff <= s_axil_awaddr;
      end else if (b_hs) begin
        s_axil_awready <= 1'b1;
      end
      if (w_hs) begin
        s_axil_wready <= 1'b0;
      end else if (b_hs) begin
        s_axil_wready <= 1'b1;
      end
      if (do_wr) begin
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_map ? `PSSSO_RESP_OKAY : `PSSSO_RESP_DECERR;
        if (wr_ctrl) begin
          ctrl_ff[7:0] <= wbyte_ff;
        end
      end else if (b_hs) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // data is held aside at w_hs and kept only if the address proves to be ctrl
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wbyte_ff <= 8'h00;
    end else if (w_hs) begin
      wbyte_ff <= s_axil_wstrb[0] ? s_axil_wdata[7:0] : ctrl_ff[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b1;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= `PSSSO_RESP_OKAY;
      force_hiz <= 1'b0;
    end else begin
      force_hiz <= wr_ctrl ? wbyte_ff[`PSSSO_CTRL_HIZ_BIT] : ctrl_ff[`PSSSO_CTRL_HIZ_BIT];
      if (ar_hs) begin
        s_axil_arready <= 1'b0;
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_word;
        s_axil_rresp <= (rd_ctrl | rd_stat) ? `PSSSO_RESP_OKAY : `PSSSO_RESP_DECERR;
      end else if (r_hs) begin
        s_axil_rvalid <= 1'b0;
        s_axil_arready <= 1'b1;
      end
    end
  end

endmodule : pssso_axil

/* verilog/pssso_sram.sv */
// Purpose: select, deselect, burst order and output drive of a pipelined sram
// Assumes: controller inputs are synchronous to aclk; the strap is static
// Notes: data pins are split into input, output and output enable
//
// Overview of operation
// - low advance_load with any chip select false starts a deselect cycle
// - after a deselect the data pins release exactly two cycles later
// - selected only with both active-low selects low and chip_select_p high
// - all synchronous inputs sampled at rising clock; only output_enable_n is async
// - write data captured and read data launched from registers on rising edges
// - burst_order_sel high gives interleaved order, low linear; held static
// - output_enable_n high releases the data pins at once, regardless of clock
// - selected with advance_load low loads new address and control
// - advance_load high steps the burst counter and ignores the address pins; here it steps only while a burst is open, in st_idle it does nothing
// - clock_suspend_n high freezes every register and output for that edge; here the AXI4-Lite port registers and force_hiz still update
// - data transfer of a load happens on the data pins two cycles later
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "pssso_params.svh"

module pssso_sram #(
  parameter int ADDR_W = 17,
  parameter int LANES = 4
) (
  input wire logic aclk, // clock, rising edge
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [ADDR_W-1:0] addr, // address pins
  input wire logic chip_select_n1, // chip select, active low
  input wire logic chip_select_n2, // chip select, active low
  input wire logic chip_select_p, // chip select, active high
  input wire logic advance_load, // low loads, high advances burst
  input wire logic read_write, // high read, low write
  input wire logic clock_suspend_n, // low runs, high suspends
  input wire logic [LANES-1:0] byte_write_n, // byte lane write enables
  input wire logic burst_order_sel, // interleaved high, linear low
  input wire logic output_enable_n, // async output enable, active low
  input wire logic [LANES*`PSSSO_LANE_W-1:0] data_pins_i, // data pins as seen
  output logic [LANES*`PSSSO_LANE_W-1:0] data_pins_o, // data pins driven value
  output logic data_pins_oe, // high while the pins are driven
  input wire logic [3:0] s_axil_awaddr, // write address
  input wire logic s_axil_awvalid, // write address valid
  output logic s_axil_awready, // write address ready
  input wire logic [31:0] s_axil_wdata, // write data
  input wire logic [3:0] s_axil_wstrb, // write strobes
  input wire logic s_axil_wvalid, // write data valid
  output logic s_axil_wready, // write data ready
  output logic [1:0] s_axil_bresp, // write response
  output logic s_axil_bvalid, // write response valid
  input wire logic s_axil_bready, // write response ready
  input wire logic [3:0] s_axil_araddr, // read address
  input wire logic s_axil_arvalid, // read address valid
  output logic s_axil_arready, // read address ready
  output logic [31:0] s_axil_rdata, // read data
  output logic [1:0] s_axil_rresp, // read response
  output logic s_axil_rvalid, // read data valid
  input wire logic s_axil_rready // read data ready
);

  localparam int DW = LANES * `PSSSO_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BW = `PSSSO_BURST_W;

  logic [DW-1:0] mem [0:DEPTH-1];

  pssso_pkg::pssso_burst_t state_ff;
  pssso_pkg::pssso_burst_t nxt_state;
  logic [ADDR_W-1:0] base_ff;
  logic [BW-1:0] cnt_ff;
  logic s1_valid_ff;
  logic s1_wr_ff;
  logic [ADDR_W-1:0] s1_addr_ff;
  logic [LANES-1:0] s1_bw_n_ff;
  logic s2_valid_ff;
  logic s2_wr_ff;
  logic [ADDR_W-1:0] s2_addr_ff;
  logic [LANES-1:0] s2_bw_n_ff;
  logic drive_ff;
  logic [DW-1:0] data_out_ff;
  logic force_hiz;
  logic adv_wr;
  logic [BW-1:0] adv_low;

  // input decode
  wire run = ~clock_suspend_n;
  wire sel = ~chip_select_n1 & ~chip_select_n2 & chip_select_p;
  wire do_load = run & ~advance_load & sel;
  wire do_desel = run & ~advance_load & ~sel;
  wire in_burst = state_ff != pssso_pkg::st_idle;
  wire do_adv = run & advance_load & in_burst;
  wire [BW-1:0] nxt_cnt = BW'(cnt_ff + 1'b1);
  wire [ADDR_W-1:0] adv_addr = {base_ff[ADDR_W-1:BW], adv_low};

  // next values of the first pipeline stage
  wire nxt_s1_valid = do_load | do_adv;
  wire nxt_s1_wr = do_load ? ~read_write : adv_wr;
  wire [ADDR_W-1:0] nxt_s1_addr = do_load ? addr : adv_addr;

  // transfer slot, two edges after the load
  wire s2_rd = s2_valid_ff & ~s2_wr_ff;
  wire s2_wr = s2_valid_ff & s2_wr_ff;
  wire [DW-1:0] old_word = mem[s2_addr_ff];
  wire [DW-1:0] nxt_word;
  wire nxt_drive = s2_rd;
  wire [DW-1:0] nxt_data_out = s2_rd ? old_word : data_out_ff;

  pssso_burst #(
    .CNT_W(BW)
  ) u_burst (
    .base_low(base_ff[BW-1:0]),
    .count(nxt_cnt),
    .interleave(burst_order_sel),
    .addr_low(adv_low)
  );

  pssso_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .status({24'h00_0000, cnt_ff, state_ff, drive_ff, s2_valid_ff, s1_valid_ff}),
    .force_hiz(force_hiz)
  );

  // per-lane merge of pin data into the stored word
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      localparam int LO = g * `PSSSO_LANE_W;
      assign nxt_word[LO +: `PSSSO_LANE_W] = s2_bw_n_ff[g] ? old_word[LO +: `PSSSO_LANE_W] :
                                             data_pins_i[LO +: `PSSSO_LANE_W];
    end
  endgenerate

  always_comb begin
    nxt_state = state_ff;
    adv_wr = 1'b0;
    unique case (state_ff)
      pssso_pkg::st_idle: adv_wr = 1'b0;
      pssso_pkg::st_rd: adv_wr = 1'b0;
      pssso_pkg::st_wr: adv_wr = 1'b1;
      default: adv_wr = 1'b0;
    endcase
    if (do_load) begin
      nxt_state = read_write ? pssso_pkg::st_rd : pssso_pkg::st_wr;
    end else if (do_desel) begin
      nxt_state = pssso_pkg::st_idle; // deselect stops a burst
    end
  end

  // burst tracking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= pssso_pkg::st_idle;
      base_ff <= '0;
      cnt_ff <= '0;
    end else if (run) begin
      state_ff <= nxt_state;
      if (do_load) begin
        base_ff <= addr;
        cnt_ff <= '0;
      end else if (do_adv) begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

  // two-stage control pipeline
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_valid_ff <= 1'b0;
      s2_valid_ff <= 1'b0;
      s1_wr_ff <= 1'b0;
      s2_wr_ff <= 1'b0;
      s1_addr_ff <= '0;
      s2_addr_ff <= '0;
      s1_bw_n_ff <= '1;
      s2_bw_n_ff <= '1;
    end else if (run) begin
      s1_valid_ff <= nxt_s1_valid;
      s1_wr_ff <= nxt_s1_wr;
      s1_addr_ff <= nxt_s1_addr;
      s1_bw_n_ff <= byte_write_n;
      s2_valid_ff <= s1_valid_ff;
      s2_wr_ff <= s1_wr_ff;
      s2_addr_ff <= s1_addr_ff;
      s2_bw_n_ff <= s1_bw_n_ff;
    end
  end

  // data registers on the pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_ff <= 1'b0;
      data_out_ff <= '0;
    end else if (run) begin
      drive_ff <= nxt_drive;
      data_out_ff <= nxt_data_out;
    end
  end

  // array write happens at the transfer edge with the pin data
  always_ff @(posedge aclk) begin
    if (run & s2_wr) begin
      mem[s2_addr_ff] <= nxt_word;
    end
  end

  assign data_pins_o = data_out_ff;
  // enable is the one path that bypasses the clock
  assign data_pins_oe = drive_ff & ~output_enable_n & ~force_hiz;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_desel_release: assert property ((do_desel ##1 run ##1 run) |=> !drive_ff)
    else $error("pins still driven two cycles after deselect");
  a_read_drive: assert property ((do_load & read_write ##1 run ##1 run) |=> drive_ff)
    else $error("read not driven two cycles after load");
  a_write_nodrive: assert property ((do_load & ~read_write ##1 run ##1 run) |=> !drive_ff)
    else $error("pins driven during a write slot");
  a_oe_async: assert property (output_enable_n |-> !data_pins_oe)
    else $error("pins driven while output enable is high");
  a_oe_cause: assert property (data_pins_oe |-> drive_ff && !output_enable_n)
    else $error("pins driven without a read in the pipe");
  a_suspend_hold: assert property (!run |=> $stable(data_out_ff) && $stable(drive_ff)
    && $stable(s1_valid_ff) && $stable(state_ff))
    else $error("state changed on a suspended edge");
  a_load_addr: assert property (do_load |=> s1_valid_ff && s1_addr_ff == $past(addr))
    else $error("load did not capture the address");
  a_desel_stage: assert property (do_desel |=> !s1_valid_ff && state_ff == pssso_pkg::st_idle)
    else $error("deselect left an operation pending");
  a_select_gate: assert property ((run & ~advance_load
    & (chip_select_n1 | chip_select_n2 | ~chip_select_p)) |=> !s1_valid_ff)
    else $error("operation started while not selected");
  a_adv_ignore: assert property ((do_adv && $stable(base_ff)) |=>
    s1_addr_ff[ADDR_W-1:BW] == base_ff[ADDR_W-1:BW])
    else $error("advance took the external address");
  a_burst_order: assert property ((do_adv & burst_order_sel) |=>
    s1_addr_ff[BW-1:0] == ($past(base_ff[BW-1:0]) ^ $past(nxt_cnt)))
    else $error("interleaved order broken");
  a_read_data: assert property ((s2_rd & run) |=> data_pins_o == $past(old_word))
    else $error("read data not launched from the array");

  // burst, pipeline and suspend checks
  a_idle_adv: assert property ((run & advance_load & ~in_burst) |=> !s1_valid_ff)
    else $error("advance with no open burst started a transfer");
  a_adv_step: assert property (do_adv |=> cnt_ff == BW'($past(cnt_ff) + 1'b1))
    else $error("burst counter did not step");
  a_burst_linear: assert property ((do_adv & ~burst_order_sel) |=>
    s1_addr_ff[BW-1:0] == BW'($past(base_ff[BW-1:0]) + $past(cnt_ff) + 1'b1))
    else $error("linear order broken");
  a_load_base: assert property (do_load |=> base_ff == $past(addr) && cnt_ff == '0)
    else $error("load did not restart the burst");
  a_load_dir: assert property (do_load |=> s1_wr_ff == !$past(read_write))
    else $error("load lost its direction");
  a_adv_dir: assert property (do_adv |=> s1_wr_ff == ($past(state_ff) == pssso_pkg::st_wr))
    else $error("burst beat changed direction");
  a_pipe_step: assert property (run |=>
    s2_valid_ff == $past(s1_valid_ff) && s2_addr_ff == $past(s1_addr_ff))
    else $error("second stage did not follow the first");
  a_desel_keep: assert property ((do_desel & s1_valid_ff) |=> s2_valid_ff)
    else $error("deselect dropped a pending transfer");
  a_suspend_pipe: assert property (!run |=> $stable(s2_valid_ff) && $stable(s2_addr_ff)
    && $stable(cnt_ff) && $stable(base_ff))
    else $error("pipeline moved on a suspended edge");

  // pin drive checks
  a_read_stage: assert property ((run & s2_rd) |=> drive_ff)
    else $error("read slot did not drive");
  a_drive_read: assert property ((run & ~s2_rd) |=> !drive_ff)
    else $error("pins driven outside a read slot");
  a_hold_out: assert property ((run & ~s2_rd) |=> $stable(data_pins_o))
    else $error("output register moved outside a read slot");
  a_hiz_ctrl: assert property (force_hiz |-> !data_pins_oe)
    else $error("pins driven while released by control");
  a_oe_follow: assert property ((drive_ff & ~output_enable_n & ~force_hiz) |-> data_pins_oe)
    else $error("read slot not driven with output enable low");

  c_read_burst: cover property (do_load & read_write ##1 do_adv ##1 do_adv ##1 do_adv);
  c_write_read: cover property (do_load & ~read_write ##1 do_load & read_write ##3 data_pins_oe);
  c_deselect: cover property (drive_ff ##0 do_desel ##3 !drive_ff);
  c_suspend_read: cover property (s1_valid_ff & ~s1_wr_ff ##1 !run ##1 run);
  c_idle_adv: cover property (run & advance_load & ~in_burst);

endmodule : pssso_sram

/* verification/pssso_ctrl_model.sv */
// Purpose: far-side memory controller view of the shared data pins
// Assumes: the bench decides when write data is offered
// Notes: a released bus shows a changing pattern, the inverse of its level at the last clock
`timescale 1ns/10ps

module pssso_ctrl_model (
  input wire logic aclk, // clock
  input wire logic drv_en, // controller drives write data
  input wire logic [35:0] drv_val, // write data from the controller
  input wire logic dev_oe, // device drives the pins
  input wire logic [35:0] dev_val, // device pin value
  output logic [35:0] pins // resolved pin level
);
  logic [35:0] last_ff = 36'h0;

  always_ff @(posedge aclk) begin
    last_ff <= pins;
  end

  always_comb begin
    if (drv_en && dev_oe) begin
      pins = {36{1'bx}}; // both ends driving: contention
    end else if (dev_oe) begin
      pins = dev_val;
    end else if (drv_en) begin
      pins = drv_val;
    end else begin
      pins = ~last_ff;
    end
  end
endmodule : pssso_ctrl_model

/* verification/tb_top.sv */
// Purpose: self-checking bench of the sram select/output block
// Assumes: ADDR_W reduced to 6; output enable held low unless a test lifts it
// Notes: op() issues one controller cycle per clock
`timescale 1ns/10ps
`include "pssso_params.svh"

module tb_top;
  localparam logic [2:0] LDR = 3'h0, LDW = 3'h1, ADV = 3'h2, DS1 = 3'h3, DS2 = 3'h4, DSP = 3'h5, SUS = 3'h7;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] addr = 6'h0;
  logic chip_select_n1 = 1'b1, chip_select_n2 = 1'b0, chip_select_p = 1'b1, advance_load = 1'b0;
  logic read_write = 1'b1, clock_suspend_n = 1'b0, burst_order_sel = 1'b0, drv_en = 1'b0;
  logic output_enable_n = 1'b0;
  logic [3:0] byte_write_n = 4'hF, s_axil_awaddr = 4'h0, s_axil_araddr = 4'h0, s_axil_wstrb = 4'hF;
  logic [35:0] drv_val = 36'h0, pins, data_pins_o;
  logic data_pins_oe, s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0, s_axil_arvalid = 1'b0;
  logic s_axil_rready = 1'b0;
  logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, v;
  logic [1:0] s_axil_bresp, s_axil_rresp, r;
  logic [35:0] exp_mem [0:15];
  int err_count = 0, tests_run = 0;

  always #10 aclk = ~aclk;

  pssso_sram #(.ADDR_W(6), .LANES(4)) i_dut (.aclk, .aresetn, .addr, .chip_select_n1, .chip_select_n2,
    .chip_select_p, .advance_load, .read_write, .clock_suspend_n, .byte_write_n, .burst_order_sel,
    .output_enable_n, .data_pins_i(pins), .data_pins_o, .data_pins_oe, .s_axil_awaddr, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
    .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata,
    .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);

  pssso_ctrl_model i_ctrl (.aclk, .drv_en, .drv_val, .dev_oe(data_pins_oe), .dev_val(data_pins_o), .pins);

  function automatic logic [35:0] pat(input int n);
    return 36'h9_0AB0_CDE0 + 36'(n) * 36'h0_0101_0101;
  endfunction : pat

  task report_and_stop;
    $display("checks run %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task chk_val(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED time %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  task chk_pins(input logic exp_oe, input logic [35:0] exp);
    chk_val({35'h0, data_pins_oe}, {35'h0, exp_oe});
    if (exp_oe) begin
      chk_val(data_pins_o, exp);
    end
  endtask : chk_pins

  task op(input logic [2:0] k, input logic [5:0] a, input logic [3:0] bwn, input logic den, input logic [35:0] d);
    @(posedge aclk);
    clock_suspend_n <= (k == SUS);
    advance_load <= (k == ADV || k == SUS);
    read_write <= (k != LDW);
    chip_select_n1 <= (k == DS1);
    chip_select_n2 <= (k == DS2);
    chip_select_p <= (k != DSP);
    addr <= a;
    byte_write_n <= bwn;
    drv_en <= den;
    drv_val <= d;
  endtask : op

  // four reads: single loads, or one load then advances with junk on the address pins
  task rd4(input logic burst, input logic [1:0] base);
    logic [1:0] n;
    for (int i = 0; i < 8; i++) begin
      op(i >= 4 ? DS1 : (burst && i > 0) ? ADV : LDR, (burst && i > 0) ? 6'h2E : burst ? {4'h0, base} : 6'(i),
        4'hF, 1'b0, 36'h0);
      n = 2'(i - 3);
      #1;
      if (i >= 3 && i < 7) begin
        chk_pins(1'b1, exp_mem[!burst ? n : burst_order_sel ? base ^ n : base + n]);
      end
      if (i == 7) begin
        chk_pins(1'b0, 36'h0);
      end
    end
  endtask : rd4

  task rd_one(input logic [2:0] k, input logic oe_n, input logic exp_oe);
    op(k, 6'h8, 4'hF, 1'b0, 36'h0);
    repeat (3) op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    output_enable_n <= oe_n;
    #1;
    chk_pins(exp_oe, exp_mem[8]);
    @(posedge aclk);
    output_enable_n <= 1'b0;
  endtask : rd_one

  task axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rr);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_awvalid <= 1'b1;
    s_axil_wdata <= d;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axil_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axil_awvalid <= 1'b0;
      end
      if (!w_ok && s_axil_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axil_wvalid <= 1'b0;
      end
    end
    while (s_axil_bvalid !== 1'b1) @(posedge aclk);
    rr = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rr);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do @(posedge aclk); while (s_axil_arready !== 1'b1);
    s_axil_arvalid <= 1'b0;
    while (s_axil_rvalid !== 1'b1) @(posedge aclk);
    d = s_axil_rdata;
    rr = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask : axi_rd

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk_pins(1'b0, 36'h0);
    chk_val({35'h0, s_axil_awready}, 36'h1);
    axi_rd(`PSSSO_CTRL_OFS, v, r);
    chk_val({4'h0, v}, {4'h0, `PSSSO_CTRL_RST});
    axi_wr(`PSSSO_CTRL_OFS, 32'h0000_005A, r);
    chk_val({34'h0, r}, {34'h0, `PSSSO_RESP_OKAY});
    axi_rd(4'h8, v, r);
    chk_val({34'h0, r}, {34'h0, `PSSSO_RESP_DECERR});
    chk_val({4'h0, v}, 36'h0);
    axi_wr(4'h8, 32'h0000_00FF, r);
    chk_val({34'h0, r}, {34'h0, `PSSSO_RESP_DECERR});
    axi_rd(`PSSSO_CTRL_OFS, v, r);
    chk_val({4'h0, v}, 36'h0_0000_005A);
    axi_rd(`PSSSO_STAT_OFS, v, r);
    chk_val({4'h0, v & 32'h0000_003F}, 36'h0_0000_0008);
    // linear write burst from 1: beats land on 1, 2, 3, 0
    for (int i = 0; i < 6; i++) begin
      op(i == 0 ? LDW : i < 4 ? ADV : DS1, i == 0 ? 6'h1 : 6'h2E, 4'h0, i >= 2, pat(i - 2));
    end
    for (int i = 0; i < 4; i++) begin
      exp_mem[(i + 1) % 4] = pat(i);
    end
    rd4(1'b0, 2'h0);
    rd4(1'b1, 2'h2);
    @(posedge aclk);
    burst_order_sel <= 1'b1;
    rd4(1'b1, 2'h1);
    // full write, lane-0 write, then read with no dead cycle
    op(LDW, 6'h8, 4'h0, 1'b0, 36'h0);
    op(LDW, 6'h8, 4'hE, 1'b0, 36'h0);
    op(LDR, 6'h8, 4'hF, 1'b1, pat(10));
    op(DS1, 6'h8, 4'hF, 1'b1, pat(11));
    exp_mem[8] = (pat(10) & 36'hF_FFFF_FE00) | (pat(11) & 36'h0_0000_01FF);
    op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    #1 chk_pins(1'b0, 36'h0);
    op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    #1 chk_pins(1'b1, exp_mem[8]);
    op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    #1 chk_pins(1'b0, 36'h0);
    // suspended edge holds the read word on the pins
    op(LDR, 6'h8, 4'hF, 1'b0, 36'h0);
    repeat (2) op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    op(SUS, 6'h8, 4'hF, 1'b0, 36'h0);
    #1 chk_pins(1'b1, exp_mem[8]);
    op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    #1 chk_pins(1'b1, exp_mem[8]);
    op(DS1, 6'h8, 4'hF, 1'b0, 36'h0);
    #1 chk_pins(1'b0, 36'h0);
    rd_one(LDR, 1'b1, 1'b0);
    for (int k = 2; k < 6; k++) begin
      rd_one(3'(k), 1'b0, 1'b0);
    end
    axi_wr(`PSSSO_CTRL_OFS, 32'h0000_0001, r);
    rd_one(LDR, 1'b0, 1'b0);
    axi_wr(`PSSSO_CTRL_OFS, 32'h0000_0000, r);
    rd_one(LDR, 1'b0, 1'b1);
    report_and_stop();
  end

  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end
endmodule : tb_top
